// >>> dv/asrp_properties.sv
`timescale 1ns/10ps
module asrp_properties (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // link signals
  input wire logic cs_n,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic sck_dev,
  input wire logic sck_dev_oe,
  input wire logic sck_host_oe,
  input wire logic sck_w
);
  logic       sck_q;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic       rise;
  logic       fall;

  // driven clock edges and rises within a frame; pull-up steps are not clock edges
  assign rise  = sck_w & ~sck_q & (sck_dev_oe | sck_host_oe);
  assign fall  = ~sck_w & sck_q & (sck_dev_oe | sck_host_oe);
  assign cnt_d = cs_n ? 5'h00 : cnt_q + {4'h0, rise && cnt_q != 5'h1F};

  // previous clock level, idle high by pull-up
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sck_q <= 1'b1;
      cnt_q <= 5'h00;
    end else begin
      sck_q <= sck_w;
      cnt_q <= cnt_d;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // frame steps
  sequence s_idle;
    cs_n [*4];
  endsequence
  sequence s_zero_bit;
    rise && !cs_n && (cnt_q inside {5'h00, 5'h01, 5'h14, 5'h15, 5'h16, 5'h17});
  endsequence
  sequence s_last_fall;
    fall && !cs_n && cnt_q == 5'h18;
  endsequence

  a_sdo_off_idle: assert property (s_idle |-> !sdo_oe)
    else $error("data output driven while deselected");
  a_clk_off_idle: assert property (s_idle |-> !sck_dev_oe)
    else $error("device clock driven while deselected");
  a_no_clk_fight: assert property (!(sck_dev_oe && sck_host_oe))
    else $error("both ends drive the clock");
  a_sdo_on_fall: assert property (sck_dev_oe && sdo_oe && $past(sdo_oe) && $changed(sdo) |-> !sck_dev)
    else $error("data changed while clock high");
  a_select_status: assert property ($fell(cs_n) |-> ##[2:4] sdo_oe)
    else $error("status not shown after select");
  a_zero_bits: assert property (s_zero_bit |-> sdo_oe && !sdo)
    else $error("fixed low bit not low");
  a_last_fall_high: assert property (s_last_fall |-> ##[0:4] (sdo_oe && sdo))
    else $error("output not high after last fall");
  a_word_length: assert property (rise && sck_dev_oe && !cs_n |-> cnt_q < 5'h18)
    else $error("more than one word of clocks");
endmodule

// >>> dv/asrp_tb.sv
`timescale 1ns/10ps
module asrp_tb;
  import asrp_pkg::*;

  typedef struct packed {
    logic [19:0] vin;
    logic        ext;
    logic [7:0]  cmd;
    logic [23:0] word;
    logic [4:0]  chan;
  } asrp_row_t;

  // input level, clock mode, input word, word it gives, channel after
  localparam asrp_row_t ROWS [7] = '{
    '{20'h00000, 1'b0, 8'hB5, 24'h200000, 5'h15},
    '{20'hFFFFF, 1'b1, 8'h00, 24'h1FFFF0, 5'h15},
    '{20'h0FFFF, 1'b0, 8'hA3, 24'h2FFFF0, 5'h03},
    '{20'h10000, 1'b1, 8'h9F, 24'h300000, 5'h03},
    '{20'hF0000, 1'b0, 8'hBE, 24'h100000, 5'h1E},
    '{20'hEFFFF, 1'b1, 8'hA0, 24'h0FFFF0, 5'h00},
    '{20'h08000, 1'b0, 8'h00, 24'h280000, 5'h00}
  };

  logic               clk_i;
  logic               rst_i;
  logic signed [19:0] vin_i;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [7:0]         paddr;
  logic [31:0]        pwdata;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic               busy;
  logic               sel;
  logic [3:0]         addr;
  logic [31:0]        d;
  logic               e;
  int                 bad_count;
  int                 n_checks;

  asrp_if i_asrp_if ();

  asrp_dev #(.CONV_CYCLES(50), .SCK_HALF(6)) i_asrp_dev (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .lnk(i_asrp_if.dev), .vin_i(vin_i),
    .busy_o(busy), .single_ended_select_o(sel), .chan_addr_o(addr));

  asrp_host i_asrp_host (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .lnk(i_asrp_if.host), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr));

  asrp_properties i_asrp_properties (
    .clk_i(clk_i), .rst_i(rst_i), .cs_n(i_asrp_if.cs_n), .sdo(i_asrp_if.sdo),
    .sdo_oe(i_asrp_if.sdo_oe), .sck_dev(i_asrp_if.sck_dev), .sck_dev_oe(i_asrp_if.sck_dev_oe),
    .sck_host_oe(i_asrp_if.sck_host_oe), .sck_w(i_asrp_if.sck_w));

  task automatic stop_test();
    if (bad_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic hang();
    bad_count++;
    stop_test();
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) hang();
    d = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // wait for sleep, set next input, start a frame, poll done, read bits
  task automatic xfer(input logic ext, input logic [7:0] cmd, input logic [4:0] nb, input logic [19:0] nv);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 500) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 500) hang();
    vin_i <= nv;
    apb(1'b1, REG_CTRL, {11'h000, nb, cmd, 6'h00, ext, 1'b1});
    n = 0;
    do begin
      apb(1'b0, REG_STAT, 32'h0);
      n++;
    end while (d[STAT_DONE] !== 1'b1 && n < 500);
    if (n >= 500) hang();
    apb(1'b0, REG_DATA, 32'h0);
  endtask

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    bad_count = 0;
    n_checks  = 0;
    rst_i     = 1'b1;
    vin_i     = ROWS[0].vin;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, unmapped places, divider refusal of zero
    apb(1'b0, REG_DIV, 32'h0);
    chk("div_reset", {24'h000000, DIV_RST}, d);
    apb(1'b0, REG_STAT, 32'h0);
    chk("stat_reset", 32'h0, d);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped_rd_err", 32'h1, {31'h0, e});
    chk("unmapped_rd_data", 32'h0, d);
    apb(1'b1, 8'h14, 32'hFFFFFFFF);
    chk("unmapped_wr_err", 32'h1, {31'h0, e});
    apb(1'b1, REG_DIV, 32'h8);
    apb(1'b1, REG_DIV, 32'h0);
    apb(1'b0, REG_DIV, 32'h0);
    chk("div", 32'h8, d);
    // ordinary frames, both clock modes
    for (int k = 0; k < 7; k++) begin
      xfer(ROWS[k].ext, ROWS[k].cmd, 5'h18, ROWS[(k + 1) % 7].vin);
      chk("word", {8'h00, ROWS[k].word}, d);
      chk("busy_after_word", 32'h1, {31'h0, busy});
      chk("channel", {27'h0, ROWS[k].chan}, {27'h0, sel, addr});
    end
    // frame cut short after five rises
    xfer(1'b0, 8'hBF, 5'h05, 20'hFFFFF);
    chk("short_bits", 32'h4, d);
    chk("busy_after_abort", 32'h1, {31'h0, busy});
    chk("channel_kept", 32'h0, {27'h0, sel, addr});
    xfer(1'b1, 8'h00, 5'h18, 20'h0FFFF);
    chk("word_after_abort", 32'h001FFFF0, d);
    // reset in mid-run
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("cs_reset", 32'h1, {31'h0, i_asrp_if.cs_n});
    chk("sdo_oe_reset", 32'h0, {31'h0, i_asrp_if.sdo_oe});
    chk("busy_reset", 32'h1, {31'h0, busy});
    chk("channel_reset", 32'h0, {27'h0, sel, addr});
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("sdo_oe_after_reset", 32'h0, {31'h0, i_asrp_if.sdo_oe});
    chk("sck_oe_after_reset", 32'h0, {31'h0, i_asrp_if.sck_dev_oe});
    xfer(1'b0, 8'h00, 5'h18, 20'h0FFFF);
    chk("word_power_up", 32'h002FFFF0, d);
    stop_test();
  end
endmodule

// >>> pkg/asrp_if.sv
`timescale 1ns/10ps
interface asrp_if;
  // driven signals
  logic cs_n;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  logic sck_dev;
  logic sck_dev_oe;
  logic sck_host;
  logic sck_host_oe;

  // resolved wires; an undriven line reads high (pull-up model)
  logic sck_w;
  logic sdo_w;
  assign sck_w = sck_dev_oe ? sck_dev : (sck_host_oe ? sck_host : 1'b1);
  assign sdo_w = sdo_oe ? sdo : 1'b1;

  modport dev (
    input  cs_n,
    input  sdi,
    input  sck_w,
    output sdo,
    output sdo_oe,
    output sck_dev,
    output sck_dev_oe
  );

  modport host (
    output cs_n,
    output sdi,
    input  sdo_w,
    input  sck_w,
    output sck_host,
    output sck_host_oe
  );
endinterface

// >>> pkg/asrp_pkg.sv
package asrp_pkg;

  // clock and link timing
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned CONV_TIME_NS    = 20000;
  localparam int unsigned CONV_CYCLES     = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SCK_HALF_NS     = 60;
  localparam int unsigned SCK_HALF_CYCLES = SCK_HALF_NS / CLK_PERIOD_NS;

  // word layout
  localparam int unsigned WORD_BITS = 24;
  localparam int unsigned IN_BITS   = 8;
  localparam int unsigned CHAN_BITS = 5;
  localparam int unsigned RES_W     = 18;
  localparam int unsigned VIN_W     = 20;
  localparam int unsigned PAD_BITS  = 4;

  // input prefix, reset channel, fixed output bits
  localparam logic [2:0]           PFX_LOAD   = 3'h5;
  localparam logic [4:0]           CHAN_RST   = 5'h00;
  localparam logic                 FILLER_BIT = 1'b0;
  localparam logic [PAD_BITS-1:0]  PAD_VAL    = 4'h0;

  // clamp codes {sign_flag, 17-bit result}
  localparam logic [17:0]          CODE_OVER   = 18'h30000;
  localparam logic [17:0]          CODE_UNDER  = 18'h0FFFF;
  localparam logic signed [19:0]   VIN_FS_POS  = 20'sh10000;
  localparam logic signed [19:0]   VIN_FS_NEG  = 20'shF0000;

  // host register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_DIV  = 8'h0C;

  localparam int unsigned CTRL_START     = 0;
  localparam int unsigned CTRL_EXT       = 1;
  localparam int unsigned CTRL_WORD_LSB  = 8;
  localparam int unsigned CTRL_NBITS_LSB = 16;
  localparam int unsigned STAT_BUSY      = 0;
  localparam int unsigned STAT_DONE      = 1;

  localparam logic [7:0] DIV_RST = 8'(SCK_HALF_CYCLES);

  typedef enum logic [1:0] {
    DS_CONV  = 2'b00,
    DS_SLEEP = 2'b01,
    DS_XFER  = 2'b10
  } asrp_dev_state_t;

  typedef enum logic [1:0] {
    HS_IDLE  = 2'b00,
    HS_EOC   = 2'b01,
    HS_SHIFT = 2'b10,
    HS_END   = 2'b11
  } asrp_host_state_t;

endpackage

// >>> rtl/asrp_dev.sv
`timescale 1ns/10ps
module asrp_dev #(
  parameter int unsigned CONV_CYCLES = asrp_pkg::CONV_CYCLES,
  parameter int unsigned SCK_HALF    = asrp_pkg::SCK_HALF_CYCLES
) (
  // clock, reset, enable
  input  wire logic                              clk_i,
  input  wire logic                              rst_i,
  input  wire logic                              ce_i,
  // serial link
  asrp_if.dev                                    lnk,
  // converter side
  input  wire logic signed [asrp_pkg::VIN_W-1:0] vin_i,
  output logic                                   busy_o,
  output logic                                   single_ended_select_o,
  output logic             [3:0]                 chan_addr_o
);
  import asrp_pkg::*;

  localparam int unsigned CNT_W = $clog2(CONV_CYCLES + 1);
  localparam int unsigned DIV_W = $clog2(SCK_HALF + 1);
  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYCLES - 1);
  localparam logic [DIV_W-1:0] DIV_LAST  = DIV_W'(SCK_HALF - 1);
  localparam logic [4:0]       BITS_LAST = 5'(WORD_BITS - 1);
  localparam logic [4:0]       BITS_ALL  = 5'(WORD_BITS);
  localparam logic [3:0]       IN_ALL    = 4'(IN_BITS);

  asrp_dev_state_t state_q, state_d;
  logic [CNT_W-1:0]     conv_cnt_q;
  logic [RES_W-1:0]     res_q, res_d;
  logic [WORD_BITS-1:0] sh_q, sh_d;
  logic [IN_BITS-1:0]   in_q;
  logic [3:0]           in_cnt_q;
  logic [4:0]           rise_cnt_q;
  logic [4:0]           fall_cnt_q;
  logic [DIV_W-1:0]     div_q;
  logic [CHAN_BITS-1:0] chan_q;
  logic cs_prev_q, sck_prev_q, ext_q, pwr_q, gen_q;
  logic sdo_q, sdo_oe_q, sck_oe_q, busy_q;
  logic cs_n_s, sck_s, sdi_s;

  // pins into the clock domain
  asrp_sync #(.W(3)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .d_i   ({lnk.cs_n, lnk.sck_w, lnk.sdi}),
    .q_o   ({cs_n_s, sck_s, sdi_s})
  );

  // edge and event decode
  wire in_xfer   = (state_q == DS_XFER);
  wire cs_fall   = cs_prev_q & ~cs_n_s;
  wire ext_w     = (cs_fall | ~pwr_q) ? ~sck_s : ext_q;
  wire int_run   = in_xfer & ~ext_w & ~cs_n_s & (fall_cnt_q != BITS_ALL);
  wire gen_tick  = int_run & (div_q == DIV_LAST);
  wire ext_rise  = sck_s & ~sck_prev_q;
  wire ext_fall  = ~sck_s & sck_prev_q;
  wire sck_rise  = in_xfer & ~cs_n_s & (ext_w ? ext_rise : gen_tick & ~gen_q);
  wire sck_fall  = in_xfer & ~cs_n_s & (ext_w ? ext_fall : gen_tick & gen_q);
  wire word_end  = sck_fall & (fall_cnt_q == BITS_LAST);
  wire aborted   = in_xfer & cs_n_s & (rise_cnt_q != 5'h00);
  wire to_sleep  = in_xfer & cs_n_s & (rise_cnt_q == 5'h00);
  wire conv_done = (state_q == DS_CONV) & (conv_cnt_q == CONV_LAST);
  wire chan_load = (in_cnt_q == IN_ALL) & (in_q[7:5] == PFX_LOAD);
  wire load_w    = (state_d == DS_XFER) & ~in_xfer;
  wire conv_in   = (state_d == DS_CONV) & (state_q != DS_CONV);

  // conversion coding with clamps
  wire over_w  = (vin_i >= VIN_FS_POS);
  wire under_w = (vin_i < VIN_FS_NEG);
  wire [RES_W-1:0] code_w = over_w  ? CODE_OVER :
                            under_w ? CODE_UNDER :
                            {~vin_i[16], vin_i[16:0]};

  // state sequencing
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      DS_CONV: begin
        if (conv_done) begin
          state_d = cs_n_s ? DS_SLEEP : DS_XFER;
        end
      end
      DS_SLEEP: begin
        if (!cs_n_s) begin
          state_d = DS_XFER;
        end
      end
      DS_XFER: begin
        if (word_end || aborted) begin
          state_d = DS_CONV;
        end else if (to_sleep) begin
          state_d = DS_SLEEP;
        end
      end
      default: state_d = DS_CONV;
    endcase
  end

  // result hold and output shifter
  always_comb begin
    res_d = conv_done ? code_w : res_q;
    if (load_w) begin
      sh_d = {1'b0, FILLER_BIT, res_d, PAD_VAL};
    end else if (sck_fall) begin
      sh_d = {sh_q[WORD_BITS-2:0], 1'b0};
    end else begin
      sh_d = sh_q;
    end
  end

  // state, result, converter timing
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q    <= DS_CONV;
      conv_cnt_q <= '0;
      res_q      <= '0;
      sh_q       <= '0;
    end else if (ce_i) begin
      state_q    <= state_d;
      res_q      <= res_d;
      sh_q       <= sh_d;
      conv_cnt_q <= conv_in ? '0 : conv_cnt_q + CNT_W'(1);
    end
  end

  // mode capture and edge history
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cs_prev_q  <= 1'b1;
      sck_prev_q <= 1'b1;
      ext_q      <= 1'b0;
      pwr_q      <= 1'b0;
    end else if (ce_i) begin
      cs_prev_q  <= cs_n_s;
      sck_prev_q <= sck_s;
      ext_q      <= ext_w;
      pwr_q      <= 1'b1;
    end
  end

  // internal clock divider
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_q <= '0;
      gen_q <= 1'b0;
    end else if (ce_i) begin
      if (!int_run) begin
        div_q <= '0;
        gen_q <= 1'b0;
      end else begin
        div_q <= gen_tick ? '0 : div_q + DIV_W'(1);
        gen_q <= gen_q ^ gen_tick;
      end
    end
  end

  // edge counters and input capture
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rise_cnt_q <= '0;
      fall_cnt_q <= '0;
      in_cnt_q   <= '0;
      in_q       <= '0;
    end else if (ce_i) begin
      if (load_w) begin
        rise_cnt_q <= '0;
        fall_cnt_q <= '0;
        in_cnt_q   <= '0;
        in_q       <= '0;
      end else begin
        if (sck_rise && rise_cnt_q != BITS_ALL) begin
          rise_cnt_q <= rise_cnt_q + 5'h01;
        end
        if (sck_fall && fall_cnt_q != BITS_ALL) begin
          fall_cnt_q <= fall_cnt_q + 5'h01;
        end
        if (sck_rise && in_cnt_q != IN_ALL) begin
          in_q     <= {in_q[IN_BITS-2:0], sdi_s};
          in_cnt_q <= in_cnt_q + 4'h1;
        end
      end
    end
  end

  // channel selection for the next conversion
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      chan_q <= CHAN_RST;
    end else if (ce_i && conv_in && in_xfer && chan_load) begin
      chan_q <= in_q[CHAN_BITS-1:0];
    end
  end

  // registered pin drivers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sdo_q    <= 1'b1;
      sdo_oe_q <= 1'b0;
      sck_oe_q <= 1'b0;
      busy_q   <= 1'b1;
    end else if (ce_i) begin
      sdo_oe_q <= ~cs_n_s;
      sdo_q    <= (state_d == DS_XFER) ? sh_d[WORD_BITS-1] :
                  (state_d == DS_CONV);
      sck_oe_q <= ((state_d == DS_XFER) | sck_oe_q) & ~ext_w & ~cs_n_s; // hold clock low until deselect
      busy_q   <= (state_d == DS_CONV);
    end
  end

  assign lnk.sdo                = sdo_q;
  assign lnk.sdo_oe             = sdo_oe_q;
  assign lnk.sck_dev            = gen_q;
  assign lnk.sck_dev_oe         = sck_oe_q;
  assign busy_o                 = busy_q;
  assign single_ended_select_o  = chan_q[4];
  assign chan_addr_o            = chan_q[3:0];

endmodule

// >>> rtl/asrp_host.sv
`timescale 1ns/10ps
module asrp_host (
  // clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // serial link
  asrp_if.host             lnk,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o
);
  import asrp_pkg::*;

  asrp_host_state_t state_q;
  logic [7:0]           tx_q, div_q, cnt_q;
  logic [4:0]           nbits_q, rcnt_q;
  logic [WORD_BITS-1:0] rx_q;
  logic ext_q, done_q, cs_n_q, sdi_q, hck_q, sck_prev_q;
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;
  logic sdo_s, sck_s;

  // link inputs into the clock domain
  asrp_sync #(.W(2)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .d_i   ({lnk.sdo_w, lnk.sck_w}),
    .q_o   ({sdo_s, sck_s})
  );

  // apb decode
  wire acc_w    = psel_i & penable_i & pready_q;
  wire wr_w     = acc_w & pwrite_i;
  wire sel_ctrl = (paddr_i == REG_CTRL);
  wire sel_stat = (paddr_i == REG_STAT);
  wire sel_data = (paddr_i == REG_DATA);
  wire sel_div  = (paddr_i == REG_DIV);
  wire mapped   = sel_ctrl | sel_stat | sel_data | sel_div;
  wire idle_w   = (state_q == HS_IDLE);
  wire start_w  = wr_w & sel_ctrl & pwdata_i[CTRL_START] & idle_w;
  wire [31:0] rd_w = sel_ctrl ? {11'h000, nbits_q, tx_q, 6'h00, ext_q, 1'b0} :
                     sel_stat ? {30'h0, done_q, ~idle_w} :
                     sel_data ? {8'h00, rx_q} :
                     sel_div  ? {24'h000000, div_q} : 32'h0;

  // clock edges: own divider or synced device clock
  wire       tick_w  = (cnt_q == div_q - 8'h01);
  wire       shift_w = (state_q == HS_SHIFT);
  wire       rise_w  = shift_w & (ext_q ? tick_w & ~hck_q : sck_s & ~sck_prev_q);
  wire       fall_w  = shift_w & (ext_q ? tick_w & hck_q : ~sck_s & sck_prev_q);
  wire [4:0] goal_w  = (nbits_q == 5'h00 || nbits_q > 5'(WORD_BITS)) ? 5'(WORD_BITS) : nbits_q;

  // apb answer, one wait state
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else if (ce_i) begin
      pready_q  <= psel_i & penable_i & ~pready_q;
      pslverr_q <= psel_i & penable_i & ~pready_q & ~mapped;
      prdata_q  <= (psel_i & ~pwrite_i) ? rd_w : 32'h0;
    end
  end

  // configuration registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_q   <= 1'b0;
      tx_q    <= 8'h00;
      nbits_q <= 5'h00;
      div_q   <= DIV_RST;
    end else if (ce_i) begin
      if (wr_w && sel_ctrl && idle_w) begin
        ext_q   <= pwdata_i[CTRL_EXT];
        tx_q    <= pwdata_i[CTRL_WORD_LSB +: 8];
        nbits_q <= pwdata_i[CTRL_NBITS_LSB +: 5];
      end else if (fall_w) begin
        tx_q    <= {tx_q[6:0], 1'b0};
      end
      if (wr_w && sel_div && idle_w && pwdata_i[7:0] != 8'h00) begin
        div_q   <= pwdata_i[7:0];
      end
    end
  end

  // transfer sequencer
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q    <= HS_IDLE;
      cs_n_q     <= 1'b1;
      sdi_q      <= 1'b0;
      hck_q      <= 1'b0;
      cnt_q      <= 8'h00;
      rcnt_q     <= 5'h00;
      rx_q       <= '0;
      done_q     <= 1'b0;
      sck_prev_q <= 1'b1;
    end else if (ce_i) begin
      sck_prev_q <= sck_s;
      unique case (state_q)
        HS_IDLE: begin
          if (start_w) begin
            state_q <= HS_EOC;
            cs_n_q  <= 1'b0;
            done_q  <= 1'b0;
            rcnt_q  <= 5'h00;
            cnt_q   <= 8'h00;
            hck_q   <= 1'b0;
            sdi_q   <= pwdata_i[CTRL_WORD_LSB + 7];
          end
        end
        HS_EOC: begin
          if (!sdo_s) begin
            state_q <= HS_SHIFT;
          end
        end
        HS_SHIFT: begin
          cnt_q <= tick_w ? 8'h00 : cnt_q + 8'h01;
          if (ext_q && tick_w) begin
            hck_q <= ~hck_q;
          end
          if (rise_w) begin
            rx_q   <= {rx_q[WORD_BITS-2:0], sdo_s};
            rcnt_q <= rcnt_q + 5'h01;
          end
          if (fall_w) begin
            sdi_q <= tx_q[6];
            if (rcnt_q == goal_w) begin
              state_q <= HS_END;
              cs_n_q  <= 1'b1;
              cnt_q   <= 8'h00;
            end
          end
        end
        HS_END: begin
          cnt_q <= cnt_q + 8'h01;
          if (tick_w) begin
            state_q <= HS_IDLE;
            done_q  <= 1'b1;
          end
        end
      endcase
    end
  end

  assign lnk.cs_n        = cs_n_q;
  assign lnk.sdi         = sdi_q;
  assign lnk.sck_host    = hck_q;
  assign lnk.sck_host_oe = ext_q;
  assign prdata_o        = prdata_q;
  assign pready_o        = pready_q;
  assign pslverr_o       = pslverr_q;

endmodule

// >>> rtl/asrp_sync.sv
`timescale 1ns/10ps
module asrp_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  // async in, synced out
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  // two flops per bit, reset high, the idle level of every synced pin but sdi (host resets it low), so no false clock or select edge follows reset
  for (genvar g = 0; g < W; g++) begin : g_bit
    logic meta_q;
    logic sync_q;
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        meta_q <= 1'b1;
        sync_q <= 1'b1;
      end else if (ce_i) begin
        meta_q <= d_i[g];
        sync_q <= meta_q;
      end
    end
    assign q_o[g] = sync_q;
  end

endmodule
